// File: rtl/ucft_top.sv
`timescale 1ns/1ps
`include "ucft_params.svh"

// What this block does
// - async double speed divides baud ticks by 8 rather than 16.
// - async double speed receiver uses 8 samples per bit, not 16.
// - double speed takes effect only in asynchronous mode; sync mode masks the select bit, so it may stay set.
// - slave transfer clock goes through synchroniser and edge detector, two clocks late.
// - sync mode uses transfer clock pin as input for slave, output for master.
// - polarity clear: data changes on rising, sampled on falling; set swaps.
// - all 30 formats: 5 to 9 data bits, none/even/odd parity, 1 or 2 stops.
// - frame order: start, data LSB first, optional parity, stop bits.
// - after a frame, next frame follows at once or line idles high.
// - transmitter and receiver share one frame format setting.
// - receiver checks only the first stop bit; frame error when it reads zero.
// - parity is xor of data bits, inverted for odd parity.
// - char size field is 3 bits, parity field 2 bits, one stop select bit.
// - transmit enable hands serial out pin from port logic to transmitter.
// - transmitter enabled in sync master mode drives the transfer clock pin.
// - a write to the data buffer loads the transmit buffer and starts sending.
// - buffer moves to shifter when idle or right after the last stop bit.
// - shifter sends at baud divisor/double-speed rate or transfer clock rate.
// - below eight data bits, unused upper written bits are dropped.
// - baud down-counter reloads at zero or on low divisor write, ticking at zero.
// - baud divisor is 12 bits, 0 to 4095.
// - in sync mode the clock pin direction picks master or slave.
// - size code 7 selects 9 bits; ninth bit comes from a separate control bit.
module ucft_top (
    // clock and reset
    input logic CLK_IN,
    input logic RESET_N_IN,
    // configuration, shared by both directions
    input ucft_pkg::ucft_cfg_s CFG_IN,
    input logic BAUD_LOW_WRITE_IN,
    // transmit data
    input logic DATA_WRITE_IN,
    input logic [7:0] DATA_IN,
    input logic NINTH_TX_BIT_IN,
    input logic TX_COMPLETE_CLEAR_IN,
    // receive data handshake
    input logic RX_READ_IN,
    // general port control of the serial out pin
    input logic PORT_DATA_IN,
    input logic PORT_OE_N_IN,
    // pins
    input logic SERIAL_IN_PIN_IN,
    input logic TRANSFER_CLOCK_PIN_IN,
    output logic SERIAL_OUT_PIN_OUT,
    output logic SERIAL_OUT_PIN_OE_N_OUT,
    output logic TRANSFER_CLOCK_PIN_OUT,
    output logic TRANSFER_CLOCK_PIN_OE_N_OUT,
    // status
    output logic TX_BUFFER_EMPTY_FLAG_OUT,
    output logic TX_COMPLETE_FLAG_OUT,
    output logic RX_COMPLETE_FLAG_OUT,
    output logic FRAME_ERROR_OUT,
    output logic [8:0] RX_DATA_OUT
);
    import ucft_pkg::*;

    localparam ucft_state_s RST_STATE = '{
        baud_cnt: `UCFT_RST_BAUD, presc: 4'h0, xck: 1'b0, xck_oe_n: `UCFT_RST_OE_N,
        tx_buf: 9'h000, buf_empty: `UCFT_RST_BUF_EMPTY, tx_state: TX_IDLE,
        tx_sh: 9'h000, tx_cnt: 4'h0, tx_par: 1'b0, txd: `UCFT_RST_LINE,
        pin_out: `UCFT_RST_LINE, pin_oe_n: `UCFT_RST_OE_N, tx_complete: 1'b0,
        rx_state: RX_IDLE, rx_os: 4'h0, rx_cnt: 4'h0, rx_sh: 9'h000,
        rx_data: 9'h000, rx_complete: 1'b0, frame_error: 1'b0};

    ucft_state_s st;
    ucft_state_s next_st;

    logic xck_level;
    logic xck_rise;
    logic xck_fall;
    logic rx_level;

    logic sync_mode;
    logic master;
    logic double_speed;
    logic [3:0] os_last;
    logic [3:0] os_mid;
    logic [3:0] nbits;
    logic baud_tick;
    logic clk_rise;
    logic clk_fall;
    logic change_edge;
    logic sample_edge;
    logic tx_tick;
    logic rx_sample;
    logic tx_owned;
    logic [8:0] wr_word;

    // slave transfer clock and serial input both cross from the pins
    ucft_sync_edge u_xck_sync (
        .clk(CLK_IN),
        .rst_n(RESET_N_IN),
        .pin_in(TRANSFER_CLOCK_PIN_IN),
        .level_out(xck_level),
        .rise_out(xck_rise),
        .fall_out(xck_fall)
    );

    ucft_sync_edge u_rx_sync (
        .clk(CLK_IN),
        .rst_n(RESET_N_IN),
        .pin_in(SERIAL_IN_PIN_IN),
        .level_out(rx_level),
        .rise_out(),
        .fall_out()
    );

    function automatic logic [3:0] data_bits(input logic [2:0] size);
        case (size)
            3'h0: data_bits = 4'h5;
            3'h1: data_bits = 4'h6;
            3'h2: data_bits = 4'h7;
            `UCFT_SIZE_NINE: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    // reserved size codes fall back to eight bits
    function automatic logic [8:0] trim(input logic [8:0] word, input logic [3:0] n);
        logic [8:0] m;
        m = 9'h000;
        for (int i = 0; i < `UCFT_DATA_MAX; i++) begin
            m[i] = (4'(i) < n);
        end
        trim = word & m;
    endfunction

    always_comb begin
        next_st = st;
        sync_mode = CFG_IN.sync_mode_sel;
        master = sync_mode & CFG_IN.clock_pin_direction;
        double_speed = CFG_IN.double_speed_sel & ~sync_mode;
        os_last = double_speed ? `UCFT_OS_LAST_DOUBLE : `UCFT_OS_LAST_NORMAL;
        os_mid = double_speed ? `UCFT_OS_MID_DOUBLE : `UCFT_OS_MID_NORMAL;
        nbits = data_bits(CFG_IN.char_size_field);
        wr_word = trim({NINTH_TX_BIT_IN, DATA_IN}, nbits);

        // baud generator
        baud_tick = (st.baud_cnt == 12'h000);
        if (baud_tick || BAUD_LOW_WRITE_IN) begin
            next_st.baud_cnt = CFG_IN.baud_divisor;
        end else begin
            next_st.baud_cnt = st.baud_cnt - 12'h001;
        end
        if (baud_tick) begin
            next_st.presc = (st.presc >= os_last) ? 4'h0 : st.presc + 4'h1;
        end

        // master clock is baud tick halved; slave clock comes from the pin
        if (master && baud_tick) begin
            next_st.xck = ~st.xck;
        end else if (!master) begin
            next_st.xck = CFG_IN.clock_polarity_sel;
        end
        next_st.xck_oe_n = ~(master & (CFG_IN.tx_enable | CFG_IN.rx_enable));
        clk_rise = master ? (baud_tick & ~st.xck) : xck_rise;
        clk_fall = master ? (baud_tick & st.xck) : xck_fall;
        change_edge = CFG_IN.clock_polarity_sel ? clk_fall : clk_rise;
        sample_edge = CFG_IN.clock_polarity_sel ? clk_rise : clk_fall;
        // equality, so a speed switch with the prescaler past the end gives no short bit
        tx_tick = sync_mode ? change_edge : (baud_tick && st.presc == os_last);

        // transmitter
        next_st.tx_par = st.tx_par;
        case (st.tx_state)
            TX_IDLE: begin
                if (tx_tick && CFG_IN.tx_enable && !st.buf_empty) begin
                    next_st.tx_state = TX_START;
                end
            end
            TX_START: begin
                if (tx_tick) begin
                    next_st.tx_state = TX_DATA;
                    next_st.tx_cnt = 4'h0;
                    next_st.txd = st.tx_sh[0];
                    next_st.tx_sh = {1'b0, st.tx_sh[8:1]};
                end
            end
            TX_DATA: begin
                if (tx_tick && st.tx_cnt == nbits - 4'h1) begin
                    if (CFG_IN.parity_mode_field[`UCFT_PARITY_ON_BIT]) begin
                        next_st.tx_state = TX_PARITY;
                        next_st.txd = st.tx_par;
                    end else begin
                        next_st.tx_state = TX_STOP1;
                        next_st.txd = 1'b1;
                    end
                end else if (tx_tick) begin
                    next_st.tx_cnt = st.tx_cnt + 4'h1;
                    next_st.txd = st.tx_sh[0];
                    next_st.tx_sh = {1'b0, st.tx_sh[8:1]};
                end
            end
            TX_PARITY: begin
                if (tx_tick) begin
                    next_st.tx_state = TX_STOP1;
                    next_st.txd = 1'b1;
                end
            end
            TX_STOP1: begin
                if (tx_tick && CFG_IN.stop_bits_sel) begin
                    next_st.tx_state = TX_STOP2;
                end else if (tx_tick) begin
                    next_st.tx_state = st.buf_empty ? TX_IDLE : TX_START;
                end
            end
            TX_STOP2: begin
                if (tx_tick) begin
                    next_st.tx_state = st.buf_empty ? TX_IDLE : TX_START;
                end
            end
            default: begin
                next_st.tx_state = TX_IDLE;
            end
        endcase

        // a fresh start bit always loads the shifter from the buffer
        if (next_st.tx_state == TX_START && st.tx_state != TX_START) begin
            next_st.tx_sh = st.tx_buf;
            next_st.tx_par = (^st.tx_buf) ^ CFG_IN.parity_mode_field[`UCFT_PARITY_ODD_BIT];
            next_st.txd = 1'b0;
            next_st.buf_empty = 1'b1;
        end else if (next_st.tx_state == TX_IDLE) begin
            next_st.txd = `UCFT_RST_LINE;
        end
        // a write in the load cycle refills the buffer behind the shifter
        if (DATA_WRITE_IN) begin
            next_st.tx_buf = wr_word;
            next_st.buf_empty = 1'b0;
        end
        // set wins over a clear arriving in the same cycle
        next_st.tx_complete = (st.tx_complete & ~TX_COMPLETE_CLEAR_IN)
            | ((st.tx_state != TX_IDLE) & (next_st.tx_state == TX_IDLE));

        // disabling waits for the frame in flight, and any buffered frame behind it, to finish
        tx_owned = CFG_IN.tx_enable | (st.tx_state != TX_IDLE);
        next_st.pin_out = tx_owned ? next_st.txd : PORT_DATA_IN;
        next_st.pin_oe_n = tx_owned ? 1'b0 : PORT_OE_N_IN;

        // receiver: async mid-bit sampling, sync on the sampling edge
        if (baud_tick && st.rx_state != RX_IDLE) begin
            next_st.rx_os = (st.rx_os >= os_last) ? 4'h0 : st.rx_os + 4'h1;
        end
        rx_sample = sync_mode ? sample_edge : (baud_tick && st.rx_os == os_mid);
        case (st.rx_state)
            RX_IDLE: begin
                next_st.rx_os = 4'h0;
                next_st.rx_cnt = 4'h0;
                if (CFG_IN.rx_enable && !rx_level) begin
                    if (!sync_mode) begin
                        next_st.rx_state = RX_START;
                    end else if (sample_edge) begin
                        next_st.rx_state = RX_DATA;
                    end
                end
            end
            RX_START: begin
                if (rx_sample) begin
                    next_st.rx_state = rx_level ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_sample) begin
                    next_st.rx_sh[st.rx_cnt] = rx_level;
                    next_st.rx_cnt = st.rx_cnt + 4'h1;
                    if (st.rx_cnt == nbits - 4'h1) begin
                        next_st.rx_state = CFG_IN.parity_mode_field[`UCFT_PARITY_ON_BIT] ?
                            RX_PARITY : RX_STOP;
                    end
                end
            end
            RX_PARITY: begin
                if (rx_sample) begin
                    next_st.rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_sample) begin
                    next_st.rx_state = RX_IDLE;
                    next_st.rx_data = trim(st.rx_sh, nbits);
                    next_st.frame_error = ~rx_level;
                end
            end
            default: begin
                next_st.rx_state = RX_IDLE;
            end
        endcase
        if (!sync_mode && !CFG_IN.rx_enable) begin
            next_st.rx_state = RX_IDLE;
        end
        next_st.rx_complete = (st.rx_complete & ~RX_READ_IN)
            | ((st.rx_state == RX_STOP) & rx_sample);
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign SERIAL_OUT_PIN_OUT = st.pin_out;
    assign SERIAL_OUT_PIN_OE_N_OUT = st.pin_oe_n;
    assign TRANSFER_CLOCK_PIN_OUT = st.xck;
    assign TRANSFER_CLOCK_PIN_OE_N_OUT = st.xck_oe_n;
    assign TX_BUFFER_EMPTY_FLAG_OUT = st.buf_empty;
    assign TX_COMPLETE_FLAG_OUT = st.tx_complete;
    assign RX_COMPLETE_FLAG_OUT = st.rx_complete;
    assign FRAME_ERROR_OUT = st.frame_error;
    assign RX_DATA_OUT = st.rx_data;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    AST_TX_DIVIDE: assert property (tx_tick && !sync_mode |-> baud_tick && st.presc == (CFG_IN.double_speed_sel ? 4'h7 : 4'hf))
        else $error("async bit tick not at divide by 8 or 16");
    AST_RX_SAMPLES: assert property (rx_sample && !sync_mode |-> st.rx_os == (CFG_IN.double_speed_sel ? 4'h3 : 4'h7))
        else $error("async sample point off the bit middle");
    AST_SYNC_NO_DOUBLE: assert property (sync_mode && tx_tick |-> change_edge)
        else $error("sync bit tick not on a clock change edge");
    AST_XCK_DIR: assert property (sync_mode && CFG_IN.tx_enable |=> TRANSFER_CLOCK_PIN_OE_N_OUT == !$past(CFG_IN.clock_pin_direction))
        else $error("transfer clock pin direction wrong");
    AST_EDGE_POL: assert property (sync_mode && !CFG_IN.clock_polarity_sel && tx_tick |-> clk_rise && !clk_fall)
        else $error("data change not on the rising edge");
    AST_START_LOW: assert property ($rose(st.tx_state == TX_START) |-> !st.txd && !$past(st.buf_empty))
        else $error("start bit not low or buffer not loaded");
    AST_STOP_HIGH: assert property (st.tx_state inside {TX_STOP1, TX_STOP2} |-> st.txd)
        else $error("stop bit not high");
    AST_PARITY_VALUE: assert property (st.tx_state == TX_PARITY |-> st.txd == st.tx_par)
        else $error("parity bit value wrong");
    AST_PIN_HANDOVER: assert property (!CFG_IN.tx_enable && st.tx_state == TX_IDLE |=> SERIAL_OUT_PIN_OUT == $past(PORT_DATA_IN))
        else $error("serial out not returned to port control");
    AST_BAUD_RELOAD: assert property (baud_tick |=> st.baud_cnt == $past(CFG_IN.baud_divisor))
        else $error("baud counter not reloaded at zero");
    AST_FRAME_ERROR: assert property (st.rx_state == RX_STOP && rx_sample |=> FRAME_ERROR_OUT == !$past(rx_level) && RX_COMPLETE_FLAG_OUT)
        else $error("frame error not from first stop bit");
    AST_BACK_TO_BACK: assert property (st.tx_state == TX_STOP1 && tx_tick && !CFG_IN.stop_bits_sel && !st.buf_empty |=> st.tx_state == TX_START)
        else $error("pending frame not started after last stop");

    COV_NINE_BIT_PARITY: cover property (CFG_IN.char_size_field == 3'h7 && st.tx_state == TX_PARITY);
    COV_TWO_STOP: cover property (st.tx_state == TX_STOP2 ##1 st.tx_state == TX_START);
    COV_SLAVE_TX: cover property (sync_mode && !master && tx_tick && st.tx_state == TX_DATA);
    COV_FRAME_ERR: cover property ($rose(FRAME_ERROR_OUT));

endmodule

// File: include/ucft_params.svh
`ifndef UCFT_PARAMS_SVH
`define UCFT_PARAMS_SVH

// oversampling: last prescaler count and mid-bit sample point
`define UCFT_OS_LAST_NORMAL 4'hf
`define UCFT_OS_LAST_DOUBLE 4'h7
`define UCFT_OS_MID_NORMAL 4'h7
`define UCFT_OS_MID_DOUBLE 4'h3

// frame format field positions and codes
`define UCFT_PARITY_ON_BIT 1
`define UCFT_PARITY_ODD_BIT 0
`define UCFT_SIZE_NINE 3'h7
`define UCFT_DATA_MAX 9

// reset values
`define UCFT_RST_LINE 1'b1
`define UCFT_RST_OE_N 1'b1
`define UCFT_RST_BUF_EMPTY 1'b1
`define UCFT_RST_BAUD 12'h000

// edge-detect latency of the external transfer clock, in system clocks
`define UCFT_SYNC_DELAY 2

`endif

// File: include/ucft_pkg.sv
package ucft_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP1 = 3'b100,
        TX_STOP2 = 3'b101
    } ucft_tx_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP = 3'b100
    } ucft_rx_e;

    typedef struct packed {
        logic sync_mode_sel;
        logic double_speed_sel;
        logic clock_polarity_sel;
        logic clock_pin_direction;
        logic [2:0] char_size_field;
        logic [1:0] parity_mode_field;
        logic stop_bits_sel;
        logic tx_enable;
        logic rx_enable;
        logic [11:0] baud_divisor;
    } ucft_cfg_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ucft_sync_s;

    typedef struct packed {
        logic [11:0] baud_cnt;
        logic [3:0] presc;
        logic xck;
        logic xck_oe_n;
        logic [8:0] tx_buf;
        logic buf_empty;
        ucft_tx_e tx_state;
        logic [8:0] tx_sh;
        logic [3:0] tx_cnt;
        logic tx_par;
        logic txd;
        logic pin_out;
        logic pin_oe_n;
        logic tx_complete;
        ucft_rx_e rx_state;
        logic [3:0] rx_os;
        logic [3:0] rx_cnt;
        logic [8:0] rx_sh;
        logic [8:0] rx_data;
        logic rx_complete;
        logic frame_error;
    } ucft_state_s;

endpackage

// File: rtl/ucft_sync_edge.sv
`timescale 1ns/1ps
`include "ucft_params.svh"

module ucft_sync_edge (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // asynchronous pin
    input logic pin_in,
    // synchronised level and edge pulses
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    import ucft_pkg::*;

    ucft_sync_s st;
    ucft_sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // edges are seen two clocks after the pin moves
    assign level_out = st.s2;
    assign rise_out = st.s2 & ~st.s3;
    assign fall_out = ~st.s2 & st.s3;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // the stages reset low, so a pin idling high shows one edge just after reset
    AST_SYNC_RISE_DELAY: assert property (rise_out && $past(rst_n, 3) |->
        $past(pin_in, `UCFT_SYNC_DELAY) && !$past(pin_in, 3))
        else $error("rise pulse not two clocks after pin rise");
    AST_SYNC_FALL_DELAY: assert property (fall_out && $past(rst_n, 3) |->
        !$past(pin_in, `UCFT_SYNC_DELAY) && $past(pin_in, 3))
        else $error("fall pulse not two clocks after pin fall");

endmodule

// File: testbench/ucft_far_end.sv
`timescale 1ns/1ps
module ucft_far_end (
    // clock
    input wire logic clk_in,
    // serial lines, seen from the far side
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    // samples mid-bit from the start edge, so the sender's tick phase does not matter
    task automatic recv(input int n, input int per, output logic [12:0] bits);
        int k;
        bits = '0;
        k = 0;
        while (line_in !== 1'b0 && k < 50000) begin
            @(negedge clk_in);
            k++;
        end
        repeat (per / 2) @(negedge clk_in);
        for (int i = 0; i < n; i++) begin
            bits[i] = line_in;
            if (i < n - 1) repeat (per) @(negedge clk_in);
        end
    endtask
    // one idle bit after the frame so a low stop bit ends cleanly
    task automatic send(input int n, input int per, input logic [12:0] bits);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_in) #1;
            line_out = i < n ? bits[i] : 1'b1;
            repeat (per - 1) @(posedge clk_in);
        end
    endtask
endmodule

// File: testbench/tb_ucft_top.sv
`timescale 1ns/1ps
module tb_ucft_top;
    import ucft_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ucft_cfg_s cfg = '0;
    logic baud_wr = 1'b0, wr = 1'b0, ninth = 1'b0, clr = 1'b0, rd = 1'b0, pd = 1'b0;
    logic poe_n = 1'b1;
    logic watch = 1'b0;
    logic [7:0] din = 8'h00;
    logic sout, sout_oe_n, xck, xck_oe_n, empty, txc, rx_complete_flag, fe, sin, pol, prev_out, prev_clk;
    logic [8:0] rxd;
    logic sck = 1'b0, slave = 1'b0;
    // master mode loops the driven clock back into the pin, slave mode uses the bench clock
    wire xin = xck_oe_n ? sck : xck;
    logic [8:0] w[2];
    logic [12:0] got;
    // released serial out pin is pulled high
    wire line = sout_oe_n ? 1'b1 : sout;
    wire [2:0] flags = {rx_complete_flag, txc, empty};
    int seed = 32'hebbc89f2;
    int n_errors = 0;
    int num_checks = 0;
    int nd, nf, per, k;
    int sizes[5] = '{0, 1, 2, 3, 7};
    int pms[3] = '{0, 2, 3};

    always #2.5 clk = ~clk;

    // slave clock at a tenth of the system clock, well below the quarter limit
    always begin
        repeat (5) @(posedge clk);
        #1 sck = slave ? ~sck : 1'b0;
    end

    ucft_top uut (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .CFG_IN(cfg), .BAUD_LOW_WRITE_IN(baud_wr),
        .DATA_WRITE_IN(wr), .DATA_IN(din), .NINTH_TX_BIT_IN(ninth),
        .TX_COMPLETE_CLEAR_IN(clr), .RX_READ_IN(rd), .PORT_DATA_IN(pd), .PORT_OE_N_IN(poe_n),
        .SERIAL_IN_PIN_IN(sin), .TRANSFER_CLOCK_PIN_IN(xin), .SERIAL_OUT_PIN_OUT(sout),
        .SERIAL_OUT_PIN_OE_N_OUT(sout_oe_n), .TRANSFER_CLOCK_PIN_OUT(xck),
        .TRANSFER_CLOCK_PIN_OE_N_OUT(xck_oe_n), .TX_BUFFER_EMPTY_FLAG_OUT(empty),
        .TX_COMPLETE_FLAG_OUT(txc), .RX_COMPLETE_FLAG_OUT(rx_complete_flag), .FRAME_ERROR_OUT(fe),
        .RX_DATA_OUT(rxd)
    );

    ucft_far_end u_far (.clk_in(clk), .line_in(line), .line_out(sin));

    task automatic check(input logic [12:0] seen, input logic [12:0] expv);
        num_checks++;
        if (seen !== expv) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // baud reload plus flag clears, only ever while the link is idle
    task automatic pulse_cfg();
        @(posedge clk) #1;
        {baud_wr, clr, rd} = 3'h7;
        @(posedge clk) #1;
        {baud_wr, clr, rd} = 3'h0;
    endtask

    task automatic wr_word(input logic [8:0] v);
        @(posedge clk) #1;
        wr = 1'b1;
        {ninth, din} = v;
        @(posedge clk) #1;
        wr = 1'b0;
        check(13'(empty), 13'h0);
    endtask

    task automatic wait_bit(input int b);
        int c;
        c = 0;
        while (flags[b] !== 1'b1 && c < 20000) begin
            @(posedge clk);
            c++;
        end
        #1;
        check(13'(flags[b]), 13'h1);
    endtask

    task automatic edge_to(input logic lvl);
        while (xck !== lvl && k < 5000) begin
            @(negedge clk);
            k++;
        end
    endtask

    function automatic logic [12:0] frame(input logic [8:0] v, input int pm, input logic [1:0] st);
        logic [12:0] f;
        int j;
        f = '1;
        f[0] = 1'b0;
        v = v & 9'((1 << nd) - 1);
        for (j = 1; j <= nd; j++) f[j] = v[j - 1];
        if (pm[1]) begin
            f[j] = ^v ^ pm[0];
            j++;
        end
        f[j +: 2] = st;
        return f & 13'((1 << nf) - 1);
    endfunction

    always @(negedge clk) begin
        if (watch && line !== prev_out) check(13'({prev_clk, xck}), 13'({pol, ~pol}));
        prev_out <= line;
        prev_clk <= xck;
    end

    initial begin
        repeat (5) @(posedge clk);
        check(13'({sout, sout_oe_n, empty, xck_oe_n}), 13'hf);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) #1;
            {pd, poe_n} = 2'($random(seed));
            repeat (2) @(posedge clk);
            #1 check(13'(sout_oe_n), 13'(poe_n));
            if (!poe_n) check(13'(sout), 13'(pd));
        end
        cfg.tx_enable = 1'b1;
        cfg.rx_enable = 1'b1;
        foreach (sizes[a]) foreach (pms[b]) for (int c = 0; c < 4; c++) begin
            nd = sizes[a] == 7 ? 9 : sizes[a] + 5;
            nf = nd + 2 + pms[b] / 2 + c % 2;
            cfg.char_size_field = 3'(sizes[a]);
            cfg.parity_mode_field = 2'(pms[b]);
            cfg.stop_bits_sel = c[0];
            cfg.double_speed_sel = c[1];
            cfg.baud_divisor = 12'($random(seed) & 1);
            per = (c[1] ? 8 : 16) * (cfg.baud_divisor + 1);
            pulse_cfg();
            w[0] = 9'($random(seed));
            w[1] = 9'($random(seed));
            fork
                for (int j = 0; j < 2; j++) begin
                    u_far.recv(nf, per, got);
                    check(got, frame(w[j], pms[b], 2'h3));
                end
                begin
                    wr_word(w[0]);
                    wait_bit(0);
                    wr_word(w[1]);
                end
            join
            wait_bit(1);
            check(13'({line, empty}), 13'h3);
            k = $random(seed) & 1;
            u_far.send(nf, per, frame(w[0], pms[b], {~k[0], k[0]}));
            wait_bit(2);
            check(13'({fe, rxd}), 13'({~k[0], w[0] & 9'((1 << nd) - 1)}));
        end
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            cfg.sync_mode_sel = 1'b1;
            cfg.clock_pin_direction = 1'b1;
            cfg.double_speed_sel = 1'b1;
            cfg.clock_polarity_sel = pol;
            cfg.baud_divisor = 12'($random(seed) & 3);
            repeat (3) @(posedge clk);
            #1 check(13'(xck_oe_n), 13'h0);
            k = 0;
            edge_to(1'b0);
            edge_to(1'b1);
            k = 0;
            edge_to(1'b0);
            edge_to(1'b1);
            check(13'(k), 13'(2 * (cfg.baud_divisor + 1)));
            pulse_cfg();
            watch = 1'b1;
            wr_word(9'($random(seed)));
            wait_bit(1);
            watch = 1'b0;
            cfg.clock_pin_direction = 1'b0;
            repeat (3) @(posedge clk);
            #1 check(13'(xck_oe_n), 13'h1);
            slave = 1'b1;
            pulse_cfg();
            wr_word(9'($random(seed)));
            wait_bit(1);
            check(13'({line, empty}), 13'h3);
            slave = 1'b0;
        end
        results();
    end

    initial begin
        #(100000 * 5);
        n_errors++;
        results();
    end
endmodule
